/* File: fsb_dbi_pkg.sv */
// Shared constants for the inverted-group data link
package fsb_dbi_pkg;
  localparam int unsigned NUM_GROUPS    = 4;
  localparam int unsigned GROUP_W       = 16;
  localparam int unsigned BUS_W         = NUM_GROUPS * GROUP_W;
  localparam int unsigned INV_THRESHOLD = 9;
  localparam int unsigned FIFO_DEPTH    = 8;
  localparam int unsigned CLK_MHZ       = 50;
  localparam int unsigned SUBPHASE_NS   = 160;
  localparam int unsigned HALF_CYCLES   = (SUBPHASE_NS * CLK_MHZ) / (2 * 1000);
  localparam int unsigned CNT_W         = 4;
  localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYCLES - 1);
  localparam logic [BUS_W-1:0] BUS_IDLE  = 64'hffff_ffff_ffff_ffff;
  localparam logic [NUM_GROUPS-1:0] FLAGS_IDLE = 4'hf;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } drv_state_e;
endpackage

/* File: fsb_dbi_if.sv */
// Link wires between the driving end and the receiving end
interface fsb_dbi_if;
  logic [fsb_dbi_pkg::BUS_W-1:0]      data_n;
  logic [fsb_dbi_pkg::NUM_GROUPS-1:0] group_invert_flags_n;
  logic [fsb_dbi_pkg::NUM_GROUPS-1:0] group_strobe_pos_n;
  logic [fsb_dbi_pkg::NUM_GROUPS-1:0] group_strobe_neg_n;
  logic                               transfer_valid_n;

  modport drv (
    output data_n,
    output group_invert_flags_n,
    output group_strobe_pos_n,
    output group_strobe_neg_n,
    output transfer_valid_n
  );

  modport rcv (
    input data_n,
    input group_invert_flags_n,
    input group_strobe_pos_n,
    input group_strobe_neg_n,
    input transfer_valid_n
  );
endinterface

/* File: fsb_dbi_drv.sv */
// Driving end: word FIFO, per-group inversion encoder and strobe generator

module word_fifo #(
  parameter int unsigned WIDTH = 64,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    wr_d;
  logic [AW-1:0]    rd_q;
  logic [AW-1:0]    rd_d;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  always_comb begin
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    in_ready  = (cnt_q != (AW+1)'(DEPTH));
    out_valid = (cnt_q != '0);
    out_data  = mem[rd_q];
    wr_d      = wr_q;
    rd_d      = rd_q;
    if (push) begin
      wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
    end
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage needs no reset; only words behind the count are ever read
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
endmodule

module fsb_dbi_drv (
  input  wire logic                               ref_clk,
  input  wire logic                               rstn,
  input  wire logic                               in_valid,
  output logic                                    in_ready,
  input  wire logic [fsb_dbi_pkg::BUS_W-1:0]      in_data,
  input  wire logic                               inv_enable,
  fsb_dbi_if.drv                                  link
);
  logic [fsb_dbi_pkg::BUS_W-1:0]      fifo_data;
  logic                               fifo_valid;
  logic                               fifo_pop;
  logic                               in_ready_w;
  logic                               in_ready_q;

  fsb_dbi_pkg::drv_state_e            state_q;
  fsb_dbi_pkg::drv_state_e            state_d;
  logic [fsb_dbi_pkg::CNT_W-1:0]      cnt_q;
  logic [fsb_dbi_pkg::CNT_W-1:0]      cnt_d;
  logic                               half_q;
  logic                               half_d;
  logic                               sel_q;
  logic                               sel_d;
  logic [fsb_dbi_pkg::BUS_W-1:0]      data_q;
  logic [fsb_dbi_pkg::BUS_W-1:0]      data_d;
  logic [fsb_dbi_pkg::NUM_GROUPS-1:0] flags_q;
  logic [fsb_dbi_pkg::NUM_GROUPS-1:0] flags_d;
  logic [fsb_dbi_pkg::NUM_GROUPS-1:0] spos_q;
  logic [fsb_dbi_pkg::NUM_GROUPS-1:0] spos_d;
  logic [fsb_dbi_pkg::NUM_GROUPS-1:0] sneg_q;
  logic [fsb_dbi_pkg::NUM_GROUPS-1:0] sneg_d;
  logic                               valid_n_q;
  logic                               valid_n_d;
  logic                               tick;

  word_fifo #(
    .WIDTH (fsb_dbi_pkg::BUS_W),
    .DEPTH (fsb_dbi_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .in_valid  (in_valid && in_ready_q),
    .in_ready  (in_ready_w),
    .in_data   (in_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  function automatic logic [4:0] count_ones(input logic [fsb_dbi_pkg::GROUP_W-1:0] v);
    logic [4:0] n;
    n = '0;
    for (int i = 0; i < fsb_dbi_pkg::GROUP_W; i++) begin
      n = n + 5'(v[i]);
    end
    return n;
  endfunction

  // A logical one is carried electrically low, so set bits are the low ones
  function automatic logic want_invert(input logic [fsb_dbi_pkg::GROUP_W-1:0] v);
    return count_ones(v) >= 5'(fsb_dbi_pkg::INV_THRESHOLD);
  endfunction

  assign in_ready = in_ready_q;
  assign link.data_n               = data_q;
  assign link.group_invert_flags_n = flags_q;
  assign link.group_strobe_pos_n   = spos_q;
  assign link.group_strobe_neg_n   = sneg_q;
  assign link.transfer_valid_n     = valid_n_q;

  always_comb begin
    logic [fsb_dbi_pkg::GROUP_W-1:0] grp;
    logic                            inv;
    grp      = '0;
    inv      = 1'b0;
    tick     = (cnt_q == fsb_dbi_pkg::HALF_LAST);
    cnt_d    = tick ? fsb_dbi_pkg::CNT_RESET : cnt_q + 1'b1;
    half_d   = half_q;
    sel_d    = sel_q;
    state_d  = state_q;
    data_d   = data_q;
    flags_d  = flags_q;
    spos_d   = spos_q;
    sneg_d   = sneg_q;
    valid_n_d = valid_n_q;
    fifo_pop = 1'b0;
    if (tick) begin
      if (!half_q) begin
        half_d = 1'b1;
        // Strobe edge mid sub-phase keeps data settled both sides of it
        if (state_q == fsb_dbi_pkg::ST_SEND) begin
          if (sel_q) begin
            sneg_d = ~sneg_q;
          end else begin
            spos_d = ~spos_q;
          end
          sel_d = ~sel_q;
        end
      end else begin
        half_d = 1'b0;
        case (state_q)
          fsb_dbi_pkg::ST_IDLE,
          fsb_dbi_pkg::ST_SEND: begin
            if (fifo_valid) begin
              fifo_pop = 1'b1;
              state_d  = fsb_dbi_pkg::ST_SEND;
              valid_n_d = 1'b0;
              for (int g = 0; g < fsb_dbi_pkg::NUM_GROUPS; g++) begin
                grp = fifo_data[g*fsb_dbi_pkg::GROUP_W +: fsb_dbi_pkg::GROUP_W];
                inv = inv_enable && want_invert(grp);
                flags_d[g] = ~inv;
                data_d[g*fsb_dbi_pkg::GROUP_W +: fsb_dbi_pkg::GROUP_W] =
                  ~(grp ^ {fsb_dbi_pkg::GROUP_W{inv}});
              end
            end else begin
              state_d   = fsb_dbi_pkg::ST_IDLE;
              valid_n_d = 1'b1;
              data_d    = fsb_dbi_pkg::BUS_IDLE;
              flags_d = fsb_dbi_pkg::FLAGS_IDLE;
            end
          end
          default: begin
            state_d   = fsb_dbi_pkg::ST_IDLE;
            valid_n_d = 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q    <= fsb_dbi_pkg::ST_IDLE;
      cnt_q      <= fsb_dbi_pkg::CNT_RESET;
      half_q     <= 1'b0;
      sel_q      <= 1'b0;
      data_q     <= fsb_dbi_pkg::BUS_IDLE;
      flags_q    <= fsb_dbi_pkg::FLAGS_IDLE;
      spos_q     <= fsb_dbi_pkg::FLAGS_IDLE;
      sneg_q     <= fsb_dbi_pkg::FLAGS_IDLE;
      valid_n_q  <= 1'b1;
      in_ready_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      half_q     <= half_d;
      sel_q      <= sel_d;
      data_q     <= data_d;
      flags_q    <= flags_d;
      spos_q     <= spos_d;
      sneg_q     <= sneg_d;
      valid_n_q  <= valid_n_d;
      // Registered ready lags by a cycle; the FIFO gates the push anyway
      in_ready_q <= in_ready_w && !(in_valid && in_ready_q);
    end
  end
endmodule

/* File: fsb_dbi_rcv.sv */
// Receiving end: synchronises link, captures on group strobes, undoes inversion
module fsb_dbi_rcv (
  input  wire logic                          ref_clk,
  input  wire logic                          rstn,
  fsb_dbi_if.rcv                             link,
  output logic                               out_valid,
  output logic [fsb_dbi_pkg::BUS_W-1:0]      out_data,
  output logic [fsb_dbi_pkg::NUM_GROUPS-1:0] out_inverted
);
  localparam int unsigned NG = fsb_dbi_pkg::NUM_GROUPS;
  localparam int unsigned GW = fsb_dbi_pkg::GROUP_W;

  logic [fsb_dbi_pkg::BUS_W-1:0] d1_q;
  logic [fsb_dbi_pkg::BUS_W-1:0] d2_q;
  logic [NG-1:0]                 f1_q;
  logic [NG-1:0]                 f2_q;
  logic [NG-1:0]                 p1_q;
  logic [NG-1:0]                 p2_q;
  logic [NG-1:0]                 p3_q;
  logic [NG-1:0]                 n1_q;
  logic [NG-1:0]                 n2_q;
  logic [NG-1:0]                 n3_q;
  logic                          v1_q;
  logic                          v2_q;
  logic [NG-1:0]                 got_q;
  logic [NG-1:0]                 got_d;
  logic [fsb_dbi_pkg::BUS_W-1:0] word_q;
  logic [fsb_dbi_pkg::BUS_W-1:0] word_d;
  logic [NG-1:0]                 inv_q;
  logic [NG-1:0]                 inv_d;
  logic                          out_valid_q;
  logic                          out_valid_d;
  logic [fsb_dbi_pkg::BUS_W-1:0] out_data_q;
  logic [fsb_dbi_pkg::BUS_W-1:0] out_data_d;
  logic [NG-1:0]                 out_inv_q;
  logic [NG-1:0]                 out_inv_d;

  assign out_valid    = out_valid_q;
  assign out_data     = out_data_q;
  assign out_inverted = out_inv_q;

  always_comb begin
    logic [NG-1:0] edge_seen;
    logic [GW-1:0] grp;
    edge_seen   = (p2_q ^ p3_q) | (n2_q ^ n3_q);
    grp         = '0;
    got_d       = got_q;
    word_d      = word_q;
    inv_d       = inv_q;
    out_valid_d = 1'b0;
    out_data_d  = out_data_q;
    out_inv_d   = out_inv_q;
    for (int g = 0; g < NG; g++) begin
      // Only sub-phases of a valid transfer are decoded
      if (edge_seen[g] && v2_q) begin
        grp      = ~d2_q[g*GW +: GW];
        inv_d[g] = ~f2_q[g];
        word_d[g*GW +: GW] = grp ^ {GW{~f2_q[g]}};
        got_d[g] = 1'b1;
      end
    end
    if (&got_d) begin
      out_valid_d = 1'b1;
      out_data_d  = word_d;
      out_inv_d   = inv_d;
      got_d       = '0;
    end
  end

  // Data and strobes see equal synchroniser depth, so they stay aligned
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      d1_q        <= fsb_dbi_pkg::BUS_IDLE;
      d2_q        <= fsb_dbi_pkg::BUS_IDLE;
      f1_q        <= fsb_dbi_pkg::FLAGS_IDLE;
      f2_q        <= fsb_dbi_pkg::FLAGS_IDLE;
      p1_q        <= fsb_dbi_pkg::FLAGS_IDLE;
      p2_q        <= fsb_dbi_pkg::FLAGS_IDLE;
      p3_q        <= fsb_dbi_pkg::FLAGS_IDLE;
      n1_q        <= fsb_dbi_pkg::FLAGS_IDLE;
      n2_q        <= fsb_dbi_pkg::FLAGS_IDLE;
      n3_q        <= fsb_dbi_pkg::FLAGS_IDLE;
      v1_q        <= 1'b0;
      v2_q        <= 1'b0;
      got_q       <= '0;
      word_q      <= '0;
      inv_q       <= '0;
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
      out_inv_q   <= '0;
    end else begin
      d1_q        <= link.data_n;
      d2_q        <= d1_q;
      f1_q        <= link.group_invert_flags_n;
      f2_q        <= f1_q;
      p1_q        <= link.group_strobe_pos_n;
      p2_q        <= p1_q;
      p3_q        <= p2_q;
      n1_q        <= link.group_strobe_neg_n;
      n2_q        <= n1_q;
      n3_q        <= n2_q;
      v1_q        <= ~link.transfer_valid_n;
      v2_q        <= v1_q;
      got_q       <= got_d;
      word_q      <= word_d;
      inv_q       <= inv_d;
      out_valid_q <= out_valid_d;
      out_data_q  <= out_data_d;
      out_inv_q   <= out_inv_d;
    end
  end
endmodule

/* File: fsb_dbi_chk.sv */
// Concurrent checks on the link between the two ends
module fsb_dbi_chk (
  input wire logic                               ref_clk,
  input wire logic                               rstn,
  input wire logic [fsb_dbi_pkg::BUS_W-1:0]      data_n,
  input wire logic [fsb_dbi_pkg::NUM_GROUPS-1:0] group_invert_flags_n,
  input wire logic [fsb_dbi_pkg::NUM_GROUPS-1:0] group_strobe_pos_n,
  input wire logic [fsb_dbi_pkg::NUM_GROUPS-1:0] group_strobe_neg_n,
  input wire logic                               transfer_valid_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_pos_q;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // Which strobe moved last; the first one after reset is the positive one
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) last_pos_q <= 1'b0;
    else if ($changed(group_strobe_pos_n)) last_pos_q <= 1'b1;
    else if ($changed(group_strobe_neg_n)) last_pos_q <= 1'b0;
  end

  sequence s_tog;
    $changed(group_strobe_pos_n) || $changed(group_strobe_neg_n);
  endsequence
  sequence s_quiet;
    !($changed(group_strobe_pos_n) || $changed(group_strobe_neg_n));
  endsequence
  sequence s_hold;
    $stable(data_n) && $stable(group_invert_flags_n) && !transfer_valid_n;
  endsequence

  a_idle_bus_high: assert property (transfer_valid_n |->
    data_n == fsb_dbi_pkg::BUS_IDLE && group_invert_flags_n == fsb_dbi_pkg::FLAGS_IDLE)
    else $error("idle link not all high");
  a_groups_together: assert property ((group_strobe_pos_n == '0 || group_strobe_pos_n == '1)
    && (group_strobe_neg_n == '0 || group_strobe_neg_n == '1))
    else $error("group strobes out of step");
  a_strobe_mid_phase: assert property ($fell(transfer_valid_n) |-> s_quiet[*4] ##1 s_tog)
    else $error("strobe not at mid sub-phase");
  a_frame_holds: assert property ($fell(transfer_valid_n) |-> ##1 s_hold[*7])
    else $error("data or flags moved within sub-phase");
  a_strobe_valid: assert property (s_tog |-> !transfer_valid_n)
    else $error("strobe edge without valid transfer");
  a_strobe_excl: assert property (
    !($changed(group_strobe_pos_n) && $changed(group_strobe_neg_n)))
    else $error("both strobes moved together");
  a_strobe_order: assert property (s_tog |-> $changed(group_strobe_pos_n) != last_pos_q)
    else $error("strobes did not alternate");
  for (genvar g = 0; g < fsb_dbi_pkg::NUM_GROUPS; g++) begin : grp
    a_inv_count: assert property (!group_invert_flags_n[g] |->
      $countones(data_n[16*g +: 16]) >= 9)
      else $error("inverted group has too few ones");
  end
endmodule

/* File: test_fsb_data_bus_inversion.sv */
// Bench for the two link ends joined by the interface
module test_fsb_data_bus_inversion;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk    = 1'b0;
  logic        rstn       = 1'b0;
  logic        in_valid   = 1'b0;
  logic [63:0] in_data    = 64'h0;
  logic        inv_enable = 1'b0;
  logic        in_ready;
  logic        out_valid;
  logic [63:0] out_data;
  logic [3:0]  out_inverted;
  logic [3:0]  pos_q      = 4'hf;
  logic [3:0]  neg_q      = 4'hf;
  logic [31:0] seed       = 32'h8fba2b16;
  logic [31:0] hi;
  logic [63:0] w_exp;
  logic [63:0] exp_q[$];
  int          mismatches = 0;
  int          compares   = 0;

  fsb_dbi_if link_if ();
  fsb_dbi_drv fsb_dbi_drv_inst (.ref_clk(ref_clk), .rstn(rstn), .in_valid(in_valid),
    .in_ready(in_ready), .in_data(in_data), .inv_enable(inv_enable), .link(link_if));
  fsb_dbi_rcv fsb_dbi_rcv_inst (.ref_clk(ref_clk), .rstn(rstn), .link(link_if),
    .out_valid(out_valid), .out_data(out_data), .out_inverted(out_inverted));
  fsb_dbi_chk chk_inst (.ref_clk(ref_clk), .rstn(rstn), .data_n(link_if.data_n),
    .group_invert_flags_n(link_if.group_invert_flags_n),
    .group_strobe_pos_n(link_if.group_strobe_pos_n),
    .group_strobe_neg_n(link_if.group_strobe_neg_n),
    .transfer_valid_n(link_if.transfer_valid_n));

  always #10 ref_clk = ~ref_clk;

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [3:0] exp_inv(input logic [63:0] w, input logic en);
    int n;
    exp_inv = 4'h0;
    for (int g = 0; g < 4; g++) begin
      n = 0;
      for (int b = 0; b < 16; b++) n += w[16*g+b];
      exp_inv[g] = en && (n >= 9);
    end
  endfunction

  // Low wire level means logical one unless the group is flagged
  function automatic logic [63:0] exp_wire(input logic [63:0] w, input logic [3:0] inv);
    for (int g = 0; g < 4; g++) exp_wire[16*g +: 16] = inv[g] ? w[16*g +: 16] : ~w[16*g +: 16];
  endfunction

  task automatic print_verdict();
    if (mismatches == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic cmp_word(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_flags(input logic [3:0] got, input logic [3:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Valid stays up between words so no edge sees it assigned twice
  task automatic send(input logic [63:0] w);
    int n;
    n = 0;
    in_valid <= 1'b1;
    in_data <= w;
    @(negedge ref_clk);
    while (in_ready !== 1'b1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    if (in_ready !== 1'b1) begin
      mismatches++;
      print_verdict();
    end
    @(posedge ref_clk);
    exp_q.push_back(w);
  endtask

  task automatic drain();
    int n;
    n = 0;
    in_valid <= 1'b0;
    while (exp_q.size() > 0 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 2000) begin
      mismatches++;
      print_verdict();
    end
    repeat (8) @(posedge ref_clk);
  endtask

  // Wire is checked at the strobe edge, while the word is still the oldest in flight
  always @(posedge ref_clk) begin
    pos_q <= link_if.group_strobe_pos_n;
    neg_q <= link_if.group_strobe_neg_n;
    if (rstn && exp_q.size() > 0 && (link_if.group_strobe_pos_n !== pos_q
        || link_if.group_strobe_neg_n !== neg_q)) begin
      cmp_flags(link_if.group_invert_flags_n, ~exp_inv(exp_q[0], inv_enable));
      cmp_word(link_if.data_n, exp_wire(exp_q[0], exp_inv(exp_q[0], inv_enable)));
    end
    if (out_valid === 1'b1) begin
      if (exp_q.size() > 0) w_exp = exp_q.pop_front();
      else w_exp = 64'hx;
      cmp_word(out_data, w_exp);
      cmp_flags(out_inverted, exp_inv(w_exp, inv_enable));
    end
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    for (int k = 0; k < 3; k++) begin
      inv_enable <= (k != 0);
      send(64'h01ff_00ff_ffff_0000);
      send(64'h0000_ffff_00ff_01ff);
      // Burst outruns the drain, so the FIFO fills and refuses
      for (int i = 0; i < 12; i++) begin
        seed = xorshift(seed);
        hi = seed;
        seed = xorshift(seed);
        send((k == 2) ? {hi | seed, seed | {hi[15:0], hi[31:16]}} : {hi, seed});
      end
      drain();
    end
    print_verdict();
  end
endmodule
